// file: rx_guard_consts.svh
`ifndef RX_GUARD_CONSTS_SVH
`define RX_GUARD_CONSTS_SVH

`define CTRL_TWO_ADDR       8'h0C
`define CTRL_TWO_RESET      8'h20
`define CTRL_TWO_WR_MASK    8'hA7
`define SAFE_MODE_BIT       7
`define BUF_ADDR_W          7
`define BUF_DATA_W          8
`define BUF_DEPTH           128

`endif

// file: rx_guard_pkg.sv
package rx_guard_pkg;

  typedef enum logic [1:0] {
    MODE_BASIC,
    MODE_EXTENDED,
    MODE_OTHER
  } op_mode_t;

  typedef enum logic [1:0] {
    TRX_OTHER,
    TRX_RX_ON,
    TRX_RX_AACK
  } trx_state_t;

  typedef enum {
    PROT_OPEN,
    PROT_HELD
  } prot_state_t;

endpackage : rx_guard_pkg

// file: frame_buffer_mem.sv
`timescale 1ns/100ps
`include "rx_guard_consts.svh"

module frame_buffer_mem #(
  parameter int ADDR_W = `BUF_ADDR_W,
  parameter int DATA_W = `BUF_DATA_W,
  parameter int DEPTH  = `BUF_DEPTH
) (
  input  wire logic              clk_sys_in,
  input  wire logic              wr_en_in,
  input  wire logic [ADDR_W-1:0] wr_addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic      [DATA_W-1:0] rd_data_out
);

  logic [DATA_W-1:0] mem_r [DEPTH];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[rd_addr_in];
  end

endmodule : frame_buffer_mem

// file: rx_frame_buffer_protection.sv
// Summary of operation
// - In any receive state, incoming radio frames keep being received, and are stored unless protection blocks them.
// - Without protection, each new received frame replaces the previous buffer contents.
// - While protected, new radio frames are blocked until the host read ends.
// - Basic mode: a frame with valid check sequence becomes protected.
// - Extended mode: a frame raising the frame-end event becomes protected.
// - Protection works only with enable set and in receive or auto-ack receive state.
// - Only radio writes are blocked; host writes over the serial port still land.
// - Chip select rising after a buffer read releases protection.
// - Leaving either protected receive state releases protection.
// - Detection threshold level setting has no effect on protection.
// - Enable is bit 7 of control register 0x0C, reset 0.
`timescale 1ns/100ps
`include "rx_guard_consts.svh"

module rx_frame_buffer_protection
  import rx_guard_pkg::*;
#(
  parameter int ADDR_W = `BUF_ADDR_W,
  parameter int DATA_W = `BUF_DATA_W
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rstn_in,
  // chip select from the host pin, active low
  input  wire logic              sel_n_in,
  // decoded host accesses, already in clk_sys domain
  input  wire logic              host_buf_read_in,
  input  wire logic              host_buf_wr_in,
  input  wire logic [ADDR_W-1:0] host_buf_addr_in,
  input  wire logic [DATA_W-1:0] host_buf_wdata_in,
  input  wire logic              host_reg_wr_in,
  input  wire logic [7:0]        host_reg_addr_in,
  input  wire logic [7:0]        host_reg_wdata_in,
  // transceiver core status
  input  wire trx_state_t        trx_state_in,
  input  wire op_mode_t          op_mode_in,
  // radio receive path
  input  wire logic              radio_frame_start_in,
  input  wire logic              radio_wr_in,
  input  wire logic [ADDR_W-1:0] radio_addr_in,
  input  wire logic [DATA_W-1:0] radio_data_in,
  input  wire logic              radio_fcs_valid_in,
  input  wire logic              radio_frame_end_event_in,
  output logic [7:0]             ctrl_two_rdata_out,
  output logic [DATA_W-1:0]      buf_rdata_out,
  output logic                   protect_active_out,
  output logic                   radio_frame_dropped_out
);

  logic [7:0]  ctrl_two_r;
  logic        sel_n_meta_r;
  logic        sel_n_sync_r;
  logic        sel_n_prev_r;
  logic        read_seen_r;
  prot_state_t prot_r;
  prot_state_t prot_nxt;
  logic        blocking_frame_r;
  logic        dropped_r;

  logic              ctrl_wr;
  logic              safe_mode_en;
  logic              in_rx_state;
  logic              prot_allowed;
  logic              lock_basic;
  logic              lock_ext;
  logic              lock_req;
  logic              sel_rise;
  logic              read_release;
  logic              prot_held;
  logic              block_now;
  logic              radio_wr_ok;
  logic              host_wr_ok;
  logic              mem_wr;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata;
  logic [7:0]        ctrl_two_nxt;

  // both receive states qualify; any other state drops protection at once
  function automatic logic is_rx_state(input trx_state_t s);
    return (s == TRX_RX_ON) || (s == TRX_RX_AACK);
  endfunction : is_rx_state

  // one decode shared by the state machine view and the output register
  function automatic logic is_held(input prot_state_t s);
    return s == PROT_HELD;
  endfunction : is_held

  assign ctrl_wr      = host_reg_wr_in && (host_reg_addr_in == `CTRL_TWO_ADDR);
  assign safe_mode_en = ctrl_two_r[`SAFE_MODE_BIT];
  assign in_rx_state  = is_rx_state(trx_state_in);
  // threshold level field is deliberately not an input here
  assign prot_allowed = safe_mode_en && in_rx_state;
  assign lock_basic   = (op_mode_in == MODE_BASIC) && radio_fcs_valid_in;
  assign lock_ext     = (op_mode_in == MODE_EXTENDED) && radio_frame_end_event_in;
  assign lock_req     = prot_allowed && (lock_basic || lock_ext);
  assign sel_rise     = sel_n_sync_r && !sel_n_prev_r;
  assign read_release = sel_rise && read_seen_r;
  assign prot_held    = is_held(prot_r);
  // a frame that started while held stays blocked to its end, even if a read release comes mid-frame; leaving the receive states unblocks it
  assign block_now    = prot_held || blocking_frame_r;
  assign radio_wr_ok  = radio_wr_in && !block_now;
  assign host_wr_ok   = host_buf_wr_in;
  assign mem_wr       = host_wr_ok || radio_wr_ok;
  // host write takes the port; radio writes are byte paced so a collision is rare
  assign mem_addr     = host_wr_ok ? host_buf_addr_in : radio_addr_in;
  assign mem_wdata    = host_wr_ok ? host_buf_wdata_in : radio_data_in;
  assign ctrl_two_nxt = (ctrl_two_r & ~`CTRL_TWO_WR_MASK) | (host_reg_wdata_in & `CTRL_TWO_WR_MASK);

  always_comb begin
    // a lock only acts from open, so it can never cancel a release
    prot_nxt = prot_r;
    unique case (prot_r)
      PROT_OPEN: begin
        if (lock_req) begin
          prot_nxt = PROT_HELD;
        end
      end
      PROT_HELD: begin
        if (!prot_allowed || read_release) begin
          prot_nxt = PROT_OPEN;
        end
      end
    endcase
  end

  // reserved read-only bits keep their reset value; only the writable mask follows the host
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_two_r <= `CTRL_TWO_RESET;
    end else if (ctrl_wr) begin
      ctrl_two_r <= ctrl_two_nxt;
    end
  end

  // chip select is a pin: two stages before any logic looks at it
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_n_meta_r <= 1'b1;
      sel_n_sync_r <= 1'b1;
      sel_n_prev_r <= 1'b1;
    end else begin
      sel_n_meta_r <= sel_n_in;
      sel_n_sync_r <= sel_n_meta_r;
      // prev stage only feeds the edge detect
      sel_n_prev_r <= sel_n_sync_r;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      read_seen_r <= 1'b0;
    end else if (host_buf_read_in) begin
      // a read starting in the release cycle counts toward the next select
      read_seen_r <= 1'b1;
    end else if (sel_rise) begin
      read_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prot_r <= PROT_OPEN;
    end else begin
      prot_r <= prot_nxt;
    end
  end

  // registered copy so the pin never shows a decode glitch
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      protect_active_out <= 1'b0;
    end else begin
      protect_active_out <= is_held(prot_nxt);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      blocking_frame_r <= 1'b0;
    end else if (radio_frame_start_in) begin
      // decided once per frame so a read release mid-frame never leaves a frame stored half old, half new
      blocking_frame_r <= prot_held;
    end else if (!in_rx_state) begin
      blocking_frame_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dropped_r <= 1'b0;
    end else begin
      // limitation: a radio byte lost to a host write in the same clock is not flagged
      dropped_r <= radio_wr_in && block_now;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_two_rdata_out <= 8'h00;
    end else begin
      // read copy lags the control register by one clock
      ctrl_two_rdata_out <= ctrl_two_r;
    end
  end

  assign radio_frame_dropped_out = dropped_r;

  // read port follows the host address; data appear one clock later
  frame_buffer_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W),
    .DEPTH  (1 << ADDR_W)
  ) u_mem (
    .clk_sys_in  (clk_sys_in),
    .wr_en_in    (mem_wr),
    .wr_addr_in  (mem_addr),
    .wr_data_in  (mem_wdata),
    .rd_addr_in  (host_buf_addr_in),
    .rd_data_out (buf_rdata_out)
  );

endmodule : rx_frame_buffer_protection

// file: rx_guard_monitor.sv
`timescale 1ns/100ps
module rx_guard_monitor
  import rx_guard_pkg::*;
(
  input wire logic       clk_sys_in,
  input wire logic       rstn_in,
  input wire logic       sel_n_in,
  input wire logic       host_buf_read_in,
  input wire trx_state_t trx_state_in,
  input wire op_mode_t   op_mode_in,
  input wire logic       radio_wr_in,
  input wire logic       radio_fcs_valid_in,
  input wire logic       radio_frame_end_event_in,
  input wire logic [7:0] ctrl_two_rdata_out,
  input wire logic       protect_active_out,
  input wire logic       radio_frame_dropped_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  // enable seen through the lagging register copy
  wire on = ctrl_two_rdata_out[7] && trx_state_in != TRX_OTHER;
  wire pa = protect_active_out;
  sequence s_read_end;
    pa && host_buf_read_in && !sel_n_in ##1 sel_n_in;
  endsequence
  a_basic_protect: assert property (on && op_mode_in == MODE_BASIC && radio_fcs_valid_in |=> pa)
    else $error("basic frame open");
  a_ext_protect: assert property (on && op_mode_in == MODE_EXTENDED && radio_frame_end_event_in |=> pa)
    else $error("extended frame open");
  a_enable_gate: assert property (!ctrl_two_rdata_out[7] |=> !pa)
    else $error("held while off");
  a_leave_release: assert property (pa && trx_state_in == TRX_OTHER |=> !pa)
    else $error("held after leaving");
  a_read_release: assert property (s_read_end |-> ##[1:6] !pa)
    else $error("held after read");
  a_hold_select: assert property ((!sel_n_in)[*4] ##0 (pa && on) |=> pa)
    else $error("released early");
  a_drop_radio: assert property (pa && radio_wr_in |=> radio_frame_dropped_out)
    else $error("radio byte passed");
  a_drop_cause: assert property (radio_frame_dropped_out |-> $past(radio_wr_in))
    else $error("drop without byte");
endmodule : rx_guard_monitor
bind rx_frame_buffer_protection rx_guard_monitor i_rx_guard_monitor (.*);

// file: host_spi_model.sv
`timescale 1ns/100ps
module host_spi_model (
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] rdata_in,
  output logic            sel_n_out = 1'b1,
  output logic            read_out = 1'b0,
  output logic            wr_out = 1'b0,
  output logic [6:0]      addr_out = 7'h2A,
  output logic [7:0]      wdata_out = 8'h5A
);
  // byte 2 rewritten, then frame read under one select; gap models a slow host
  task automatic access(input logic [7:0] b, input int gap, output logic [31:0] d);
    sel_n_out = 1'b0;
    wr_out = 1'b1;
    addr_out = 7'h02;
    wdata_out = b;
    @(posedge clk_sys_in) #1;
    wr_out = 1'b0;
    wdata_out = ~b;
    read_out = 1'b1;
    for (int k = 0; k < 4; k++) begin
      addr_out = 7'(k);
      repeat (gap + 1) @(posedge clk_sys_in) #1;
      d[8*k+:8] = rdata_in;
    end
    sel_n_out = 1'b1;
    read_out = 1'b0;
    addr_out = ~addr_out;
  endtask : access
endmodule : host_spi_model

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import rx_guard_pkg::*;
  logic clk_sys_in = 1'b0, rstn_in = 1'b0, host_reg_wr_in = 1'b0, radio_frame_start_in = 1'b0, radio_wr_in = 1'b0;
  logic radio_fcs_valid_in = 1'b0, radio_frame_end_event_in = 1'b0, pe;
  logic [7:0] host_reg_addr_in = 8'h00, host_reg_wdata_in = 8'h00, radio_data_in = 8'h00;
  logic [6:0] radio_addr_in = 7'h00;
  trx_state_t trx_state_in = TRX_RX_ON;
  op_mode_t op_mode_in = MODE_BASIC;
  wire sel_n_in, host_buf_read_in, host_buf_wr_in, protect_active_out, radio_frame_dropped_out;
  wire [6:0] host_buf_addr_in;
  wire [7:0] host_buf_wdata_in, ctrl_two_rdata_out, buf_rdata_out;
  logic [31:0] v, d, mem, got;
  int fail_count = 0, cmp_count = 0, seed = 25;
  rx_frame_buffer_protection i_rx_frame_buffer_protection (.*);
  host_spi_model i_host_spi_model (.clk_sys_in, .rdata_in(buf_rdata_out), .sel_n_out(sel_n_in),
    .read_out(host_buf_read_in), .wr_out(host_buf_wr_in), .addr_out(host_buf_addr_in), .wdata_out(host_buf_wdata_in));
  initial forever #20 clk_sys_in = ~clk_sys_in;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in) #1;
  endtask : tick
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic reg_write(input logic [7:0] a, input logic [7:0] b);
    {host_reg_addr_in, host_reg_wdata_in, host_reg_wr_in} = {a, b, 1'b1};
    tick(1);
    host_reg_wr_in = 1'b0;
    tick(2);
  endtask : reg_write
  task automatic frame(input logic [31:0] b);
    radio_frame_start_in = 1'b1;
    tick(1);
    {radio_frame_start_in, radio_wr_in} = 2'b01;
    for (int k = 0; k < 4; k++) begin
      {radio_addr_in, radio_data_in} = {7'(k), b[8*k+:8]};
      tick(1);
    end
    radio_wr_in = 1'b0;
  endtask : frame
  function automatic logic exp_prot(logic en, trx_state_t s, op_mode_t m, logic f, logic e);
    return en && s != TRX_OTHER && (m == MODE_BASIC && f || m == MODE_EXTENDED && e);
  endfunction : exp_prot
  initial begin
    repeat (8000) @(posedge clk_sys_in);
    fail_count++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk_sys_in);
    #1 rstn_in = 1'b1;
    tick(2);
    check(ctrl_two_rdata_out, 8'h20);
    reg_write(8'h0D, 8'hFF);
    check(ctrl_two_rdata_out, 8'h20);
    for (int i = 0; i < 24; i++) begin
      v = $random(seed);
      // first two passes keep the random enable, later ones force it on
      reg_write(8'h0C, v[7:0] | {i > 1, 7'h00});
      check(ctrl_two_rdata_out, v[7:0] & 8'hA7 | {i > 1, 7'h00});
      op_mode_in = op_mode_t'(v[9:8] % 2'd3);
      trx_state_in = v[10] ? TRX_RX_AACK : TRX_RX_ON;
      d = $random(seed);
      frame(d);
      check(radio_frame_dropped_out, 1'b0);
      mem = d;
      if (!v[11]) trx_state_in = TRX_OTHER;
      {radio_frame_end_event_in, radio_fcs_valid_in} = v[14:13];
      pe = exp_prot(v[7] || i > 1, trx_state_in, op_mode_in, v[13], v[14]);
      tick(1);
      {radio_frame_end_event_in, radio_fcs_valid_in} = 2'b00;
      trx_state_in = v[10] ? TRX_RX_AACK : TRX_RX_ON;
      tick(1);
      check(protect_active_out, pe);
      d = $random(seed);
      frame(d);
      check(radio_frame_dropped_out, pe);
      if (!pe) mem = d;
      mem[23:16] = v[23:16];
      if (v[15]) begin
        trx_state_in = TRX_OTHER;
        tick(2);
        check(protect_active_out, 1'b0);
      end
      i_host_spi_model.access(v[23:16], v[17:16], got);
      check(got, mem);
      tick(6);
      check(protect_active_out, 1'b0);
    end
    test_done();
  end
endmodule : tb_top
